// ---- src/pdps_pkg.sv ----
/*
  Constants for the pad pull-down and power-save register bank: register
  addresses, field positions, reset values and timing counts.
  Assumes a 16-bit register port with byte addresses on a 20 MHz clock.
*/
package pdps_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 16;

  //////////////////////////////////////////////////////////////////////////////
  // register addresses
  localparam logic [15:0] ADDR_RSVD_GAP   = 16'h0466;
  localparam logic [15:0] ADDR_PORT_PD    = 16'h0468;
  localparam logic [15:0] ADDR_MEM_PD_LO  = 16'h046a;
  localparam logic [15:0] ADDR_MEM_PD_HI  = 16'h046c;
  localparam logic [15:0] ADDR_STRAP_PD   = 16'h046e;
  localparam logic [15:0] ADDR_PWR_SAVE   = 16'h0470;
  localparam logic [15:0] ADDR_BTO_CTRL   = 16'h0472;
  localparam logic [15:0] ADDR_IRQ_STATUS = 16'h0480;
  localparam logic [15:0] ADDR_IRQ_MASK   = 16'h0482;
  localparam logic [15:0] ADDR_STRAP_VAL  = 16'h0484;

  //////////////////////////////////////////////////////////////////////////////
  // field positions and widths
  localparam int unsigned HI_PORT_LSB   = 8;
  localparam int unsigned HI_PORT_W     = 6;
  localparam int unsigned LO_PORT_LSB   = 0;
  localparam int unsigned LO_PORT_W     = 5;
  localparam int unsigned MEM_DQ_W      = 32;
  localparam int unsigned STRAP_W       = 9;
  localparam int unsigned PWR_SAVE_BIT  = 0;
  localparam int unsigned BTO_DIS_BIT   = 0;
  localparam int unsigned BTO_IRQ_DIS_BIT = 1;
  localparam int unsigned BTO_FLAG_BIT  = 2;
  localparam int unsigned IRQ_W         = 2;
  localparam int unsigned IRQ_BTO_BIT   = 0;
  localparam int unsigned IRQ_PWR_BIT   = 1;

  //////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [15:0] RST_PD_CTRL     = 16'h0000;
  localparam logic        RST_PWR_SAVE    = 1'h1;
  localparam logic        RST_BTO_DIS     = 1'h1;
  localparam logic        RST_BTO_IRQ_DIS = 1'h0;
  localparam logic [1:0]  RST_IRQ         = 2'h0;

  //////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned BTO_TIME_NS     = 12800;
  localparam int unsigned BTO_CYCLES      = BTO_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned STRAP_SETTLE_CYC = 4;

endpackage : pdps_pkg

// ---- src/pdps_strap_if.sv ----
/*
  Interface carrying the latched configuration strap value from the strap
  latch to the register bank.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface pdps_strap_if #(parameter int unsigned W = 9);
  logic [W-1:0] strap_val;
  logic         strap_valid;

  modport prod (output strap_val, output strap_valid);
  modport cons (input strap_val, input strap_valid);
endinterface : pdps_strap_if

// ---- src/pdps_strap_latch.sv ----
/*
  Configuration strap latch: synchronises the strap pins and freezes their
  level once, shortly after reset release.
  Assumes the straps are steady around reset release.
*/
`timescale 1ns/10ps
module pdps_strap_latch
  import pdps_pkg::*;
#(
  parameter int unsigned W = STRAP_W
) (
  input  wire logic         clock_i,     // register clock
  input  wire logic         rst_n_i,     // async reset, active low
  input  wire logic [W-1:0] strap_pins_i, // raw strap pin levels
  pdps_strap_if.prod        sif          // latched value out
);

  logic [W-1:0] sync1_reg, sync2_reg, sync3_reg;
  logic [W-1:0] val_reg, val_next;
  logic         valid_reg, valid_next;
  logic [2:0]   settle_reg, settle_next;
  logic [W-1:0] agree;

  // three-stage synchroniser per pin; only stage two reads stage one
  for (genvar i = 0; i < W; i++) begin : g_sync
    always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        sync1_reg[i] <= 1'b0;
        sync2_reg[i] <= 1'b0;
        sync3_reg[i] <= 1'b0;
      end else begin
        sync1_reg[i] <= strap_pins_i[i];
        sync2_reg[i] <= sync1_reg[i];
        sync3_reg[i] <= sync2_reg[i];
      end
    end
    assign agree[i] = (sync2_reg[i] == sync3_reg[i]);
  end

  // captured once; later pull-down changes cannot disturb it
  always_comb begin
    settle_next = settle_reg;
    val_next    = val_reg;
    valid_next  = valid_reg;
    if (!valid_reg) begin
      if (settle_reg != 3'(STRAP_SETTLE_CYC)) begin
        settle_next = settle_reg + 3'h1;
      end else if (&agree) begin
        val_next   = sync3_reg;
        valid_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      settle_reg <= 3'h0;
      val_reg    <= '0;
      valid_reg  <= 1'b0;
    end else begin
      settle_reg <= settle_next;
      val_reg    <= val_next;
      valid_reg  <= valid_next;
    end
  end

  assign sif.strap_val   = val_reg;
  assign sif.strap_valid = valid_reg;

  chk_strap_frozen: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_reg |=> valid_reg && $stable(val_reg))
    else $error("latched strap value changed after capture");

endmodule // pdps_strap_latch

// ---- src/pdps_regs.sv ----
/*
  Pad pull-down, power-save and bus time-out register bank. Holds the
  pull-down controls of the port groups, memory data lines and strap pins,
  the power-save switch and the bus time-out reset controls.
  Assumes a single-cycle register port with read data one cycle later,
  and a host interface that raises host_access_pending_i while an access
  waits on the internal bus.
*/
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
module pdps_regs
  import pdps_pkg::*;
#(
  parameter int unsigned BTO_CNT = BTO_CYCLES
) (
  input  wire logic                 clock_i,                   // register clock
  input  wire logic                 rst_n_i,                   // async reset, active low
  input  wire logic [ADDR_W-1:0]    addr_i,                    // register byte address
  input  wire logic [DATA_W-1:0]    wr_data_i,                 // write data
  input  wire logic                 wr_en_i,                   // write strobe
  input  wire logic                 rd_en_i,                   // read strobe
  output logic      [DATA_W-1:0]    rd_data_o,                 // read data, next cycle
  input  wire logic                 host_access_pending_i,     // host access waiting
  input  wire logic [STRAP_W-1:0]   config_strap_pins_i,       // strap pin levels
  output logic [HI_PORT_W-1:0]      high_port_group_pd_en_o,   // pull-down on
  output logic [LO_PORT_W-1:0]      second_port_group_pd_en_o, // pull-down on
  output logic [MEM_DQ_W-1:0]       memory_data_lines_pd_en_o, // pull-down on
  output logic [STRAP_W-1:0]        config_strap_pins_pd_en_o, // pull-down on
  output logic                      io_clk_en_o,               // I/O clock enable
  output logic                      chip_reset_o,              // whole-device reset
  output logic [STRAP_W-1:0]        config_strap_o,            // latched straps
  output logic                      config_strap_valid_o,      // straps latched
  output logic                      irq_o                      // level interrupt
);

  localparam int unsigned CNT_W = $clog2(BTO_CNT + 1);

  //////////////////////////////////////////////////////////////////////////////
  // strap latch

  pdps_strap_if #(.W(STRAP_W)) strap_if ();

  pdps_strap_latch #(.W(STRAP_W)) u_strap_latch (
    .clock_i      (clock_i),
    .rst_n_i      (rst_n_i),
    .strap_pins_i (config_strap_pins_i),
    .sif          (strap_if.prod)
  );

  //////////////////////////////////////////////////////////////////////////////
  // register state

  logic [HI_PORT_W-1:0] port_hi_reg, port_hi_next;
  logic [LO_PORT_W-1:0] port_lo_reg, port_lo_next;
  logic [MEM_DQ_W-1:0]  mem_reg, mem_next;
  logic [STRAP_W-1:0]   strap_pd_reg, strap_pd_next;
  logic                 pwr_save_reg, pwr_save_next;
  logic                 bto_dis_reg, bto_dis_next;
  logic                 bto_irq_dis_reg, bto_irq_dis_next;
  logic                 bto_flag_reg, bto_flag_next;
  logic [IRQ_W-1:0]     irq_stat_reg, irq_stat_next;
  logic [IRQ_W-1:0]     irq_mask_reg, irq_mask_next;

  logic wr_port, wr_mem_lo, wr_mem_hi, wr_strap, wr_pwr, wr_bto, wr_mask;
  logic rd_stat;
  logic bto_evt, pwr_evt;
  logic [IRQ_W-1:0] irq_evt;

  // the reserved gap at ADDR_RSVD_GAP decodes to nothing, so writes vanish
  assign wr_port   = wr_en_i && (addr_i == ADDR_PORT_PD);
  assign wr_mem_lo = wr_en_i && (addr_i == ADDR_MEM_PD_LO);
  assign wr_mem_hi = wr_en_i && (addr_i == ADDR_MEM_PD_HI);
  assign wr_strap  = wr_en_i && (addr_i == ADDR_STRAP_PD);
  assign wr_pwr    = wr_en_i && (addr_i == ADDR_PWR_SAVE);
  assign wr_bto    = wr_en_i && (addr_i == ADDR_BTO_CTRL);
  assign wr_mask   = wr_en_i && (addr_i == ADDR_IRQ_MASK);
  assign rd_stat   = rd_en_i && (addr_i == ADDR_IRQ_STATUS);

  // entering power save is reported so software can see it took effect
  assign pwr_evt = wr_pwr && wr_data_i[PWR_SAVE_BIT] && !pwr_save_reg;

  always_comb begin
    port_hi_next     = port_hi_reg;
    port_lo_next     = port_lo_reg;
    mem_next         = mem_reg;
    strap_pd_next    = strap_pd_reg;
    pwr_save_next    = pwr_save_reg;
    bto_dis_next     = bto_dis_reg;
    bto_irq_dis_next = bto_irq_dis_reg;
    irq_mask_next    = irq_mask_reg;
    if (wr_port) begin
      port_hi_next = wr_data_i[HI_PORT_LSB +: HI_PORT_W];
      port_lo_next = wr_data_i[LO_PORT_LSB +: LO_PORT_W];
    end
    if (wr_mem_lo) begin
      mem_next[15:0] = wr_data_i;
    end
    if (wr_mem_hi) begin
      mem_next[31:16] = wr_data_i;
    end
    if (wr_strap) begin
      strap_pd_next = wr_data_i[STRAP_W-1:0];
    end
    if (wr_pwr) begin
      pwr_save_next = wr_data_i[PWR_SAVE_BIT];
    end
    if (wr_bto) begin
      bto_dis_next     = wr_data_i[BTO_DIS_BIT];
      bto_irq_dis_next = wr_data_i[BTO_IRQ_DIS_BIT];
    end
    if (wr_mask) begin
      irq_mask_next = wr_data_i[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_hi_reg     <= RST_PD_CTRL[HI_PORT_LSB +: HI_PORT_W];
      port_lo_reg     <= RST_PD_CTRL[LO_PORT_LSB +: LO_PORT_W];
      mem_reg         <= {RST_PD_CTRL, RST_PD_CTRL};
      strap_pd_reg    <= RST_PD_CTRL[STRAP_W-1:0];
      pwr_save_reg    <= RST_PWR_SAVE;
      bto_dis_reg     <= RST_BTO_DIS;
      bto_irq_dis_reg <= RST_BTO_IRQ_DIS;
      irq_mask_reg    <= RST_IRQ;
    end else begin
      port_hi_reg     <= port_hi_next;
      port_lo_reg     <= port_lo_next;
      mem_reg         <= mem_next;
      strap_pd_reg    <= strap_pd_next;
      pwr_save_reg    <= pwr_save_next;
      bto_dis_reg     <= bto_dis_next;
      bto_irq_dis_reg <= bto_irq_dis_next;
      irq_mask_reg    <= irq_mask_next;
    end
  end

  // a 0 bit leaves the pull-down on
  assign high_port_group_pd_en_o   = ~port_hi_reg;
  assign second_port_group_pd_en_o = ~port_lo_reg;
  assign memory_data_lines_pd_en_o = ~mem_reg;
  assign config_strap_pins_pd_en_o = ~strap_pd_reg;

  // only I/O clocks stop; this bank stays on the host bus clock
  assign io_clk_en_o = !pwr_save_reg;

  //////////////////////////////////////////////////////////////////////////////
  // bus time-out watchdog

  logic [CNT_W-1:0] bto_cnt_reg, bto_cnt_next;
  logic             chip_rst_reg, chip_rst_next;

  assign bto_evt = host_access_pending_i && (bto_cnt_reg == CNT_W'(BTO_CNT - 1));

  always_comb begin
    bto_cnt_next  = '0;
    if (host_access_pending_i && !bto_evt) begin
      bto_cnt_next = bto_cnt_reg + CNT_W'(1);
    end
    chip_rst_next = bto_evt && !bto_dis_reg;
    bto_flag_next = bto_flag_reg;
    if (wr_bto && wr_data_i[BTO_IRQ_DIS_BIT]) begin
      bto_flag_next = 1'b0;
    end
    // a time-out in the clearing cycle is kept
    if (bto_evt && !bto_dis_reg && !bto_irq_dis_reg) begin
      bto_flag_next = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bto_cnt_reg  <= '0;
      chip_rst_reg <= 1'b0;
      bto_flag_reg <= 1'b0;
    end else begin
      bto_cnt_reg  <= bto_cnt_next;
      chip_rst_reg <= chip_rst_next;
      bto_flag_reg <= bto_flag_next;
    end
  end

  assign chip_reset_o = chip_rst_reg;

  //////////////////////////////////////////////////////////////////////////////
  // interrupt status, cleared by reading it

  always_comb begin
    irq_evt              = '0;
    irq_evt[IRQ_BTO_BIT] = bto_evt && !bto_dis_reg && !bto_irq_dis_reg;
    irq_evt[IRQ_PWR_BIT] = pwr_evt;
    irq_stat_next = rd_stat ? irq_evt : (irq_stat_reg | irq_evt);
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_reg <= RST_IRQ;
    end else begin
      irq_stat_reg <= irq_stat_next;
    end
  end

  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  //////////////////////////////////////////////////////////////////////////////
  // read path

  logic [DATA_W-1:0] rd_mux, rd_data_reg, rd_data_next;

  always_comb begin
    rd_mux = '0;
    case (addr_i)
      ADDR_PORT_PD: begin
        rd_mux[HI_PORT_LSB +: HI_PORT_W] = port_hi_reg;
        rd_mux[LO_PORT_LSB +: LO_PORT_W] = port_lo_reg;
      end
      ADDR_MEM_PD_LO:  rd_mux = mem_reg[15:0];
      ADDR_MEM_PD_HI:  rd_mux = mem_reg[31:16];
      ADDR_STRAP_PD:   rd_mux[STRAP_W-1:0] = strap_pd_reg;
      ADDR_PWR_SAVE:   rd_mux[PWR_SAVE_BIT] = pwr_save_reg;
      ADDR_BTO_CTRL: begin
        rd_mux[BTO_DIS_BIT]     = bto_dis_reg;
        rd_mux[BTO_IRQ_DIS_BIT] = bto_irq_dis_reg;
        rd_mux[BTO_FLAG_BIT]    = bto_flag_reg;
      end
      ADDR_IRQ_STATUS: rd_mux[IRQ_W-1:0] = irq_stat_reg;
      ADDR_IRQ_MASK:   rd_mux[IRQ_W-1:0] = irq_mask_reg;
      ADDR_STRAP_VAL: begin
        rd_mux[STRAP_W-1:0] = strap_if.strap_val;
        rd_mux[DATA_W-1]    = strap_if.strap_valid;
      end
      default:         rd_mux = '0;
    endcase
    rd_data_next = rd_en_i ? rd_mux : '0;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_reg <= '0;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data_o            = rd_data_reg;
  assign config_strap_o       = strap_if.strap_val;
  assign config_strap_valid_o = strap_if.strap_valid;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_bto_fire;
    bto_evt && !bto_dis_reg && !bto_irq_dis_reg;
  endsequence

  sequence s_flag_clear_wr;
    wr_en_i && (addr_i == ADDR_BTO_CTRL) && wr_data_i[BTO_IRQ_DIS_BIT] && !bto_evt;
  endsequence

  chk_port_hi_map: assert property (
    wr_en_i && addr_i == ADDR_PORT_PD |=>
      high_port_group_pd_en_o == ~$past(wr_data_i[13:8]))
    else $error("high port pull-downs do not follow bits 13..8");

  chk_port_lo_map: assert property (
    wr_en_i && addr_i == ADDR_PORT_PD |=>
      second_port_group_pd_en_o == ~$past(wr_data_i[4:0]))
    else $error("second port pull-downs do not follow bits 4..0");

  chk_mem_hi_map: assert property (
    wr_en_i && addr_i == ADDR_MEM_PD_HI |=>
      memory_data_lines_pd_en_o[31:16] == ~$past(wr_data_i))
    else $error("memory lines 31..16 pull-downs wrong");

  chk_strap_unused: assert property (
    rd_en_i && addr_i == ADDR_STRAP_PD |=> rd_data_o[15:9] == 7'h00)
    else $error("unused strap register bits read non-zero");

  chk_rsvd_quiet: assert property (
    rd_en_i && addr_i == ADDR_RSVD_GAP |=> rd_data_o == 16'h0000)
    else $error("reserved register read non-zero");

  chk_pwr_gate: assert property (
    wr_en_i && addr_i == ADDR_PWR_SAVE |=> io_clk_en_o == !$past(wr_data_i[0]))
    else $error("power-save bit does not gate the I/O clocks");

  chk_bto_reset: assert property (
    bto_evt |=> chip_reset_o == !$past(bto_dis_reg) ##1 !chip_reset_o)
    else $error("time-out reset does not follow its disable bit");

  chk_flag_raise: assert property (
    s_bto_fire |=> bto_flag_reg ##1 (bto_flag_reg || $past(wr_bto)))
    else $error("time-out flag not raised");

  chk_flag_clear: assert property (
    s_flag_clear_wr |=> !bto_flag_reg)
    else $error("time-out flag not cleared by disabling the interrupt");

  chk_rd_once: assert property (
    !rd_en_i |=> rd_data_o == 16'h0000)
    else $error("read data present without a read");

endmodule // pdps_regs

// ---- tb/tb_pdps_regs.sv ----
/*
  Self-checking bench for the pad pull-down, power-save and bus time-out
  register bank: register reset values, pull-down mapping, strap capture,
  power save, interrupt status/mask and the bus time-out reset.
  Assumes the package constants and a shortened time-out count of 8.
*/
`timescale 1ns/10ps
module tb_pdps_regs;
  import pdps_pkg::*;

  localparam int unsigned TB_BTO = 8;

  logic                   clock_i;
  logic                   rst_n_i;
  logic [ADDR_W-1:0]      addr_i;
  logic [DATA_W-1:0]      wr_data_i;
  logic                   wr_en_i;
  logic                   rd_en_i;
  logic [DATA_W-1:0]      rd_data_o;
  logic                   host_access_pending_i;
  logic [STRAP_W-1:0]     config_strap_pins_i;
  logic [HI_PORT_W-1:0]   high_port_group_pd_en_o;
  logic [LO_PORT_W-1:0]   second_port_group_pd_en_o;
  logic [MEM_DQ_W-1:0]    memory_data_lines_pd_en_o;
  logic [STRAP_W-1:0]     config_strap_pins_pd_en_o;
  logic                   io_clk_en_o;
  logic                   chip_reset_o;
  logic [STRAP_W-1:0]     config_strap_o;
  logic                   config_strap_valid_o;
  logic                   irq_o;
  int                     errors;
  int                     num_checks;
  int                     pulses;

  pdps_regs #(.BTO_CNT(TB_BTO)) i_dut (
    .clock_i                   (clock_i),
    .rst_n_i                   (rst_n_i),
    .addr_i                    (addr_i),
    .wr_data_i                 (wr_data_i),
    .wr_en_i                   (wr_en_i),
    .rd_en_i                   (rd_en_i),
    .rd_data_o                 (rd_data_o),
    .host_access_pending_i     (host_access_pending_i),
    .config_strap_pins_i       (config_strap_pins_i),
    .high_port_group_pd_en_o   (high_port_group_pd_en_o),
    .second_port_group_pd_en_o (second_port_group_pd_en_o),
    .memory_data_lines_pd_en_o (memory_data_lines_pd_en_o),
    .config_strap_pins_pd_en_o (config_strap_pins_pd_en_o),
    .io_clk_en_o               (io_clk_en_o),
    .chip_reset_o              (chip_reset_o),
    .config_strap_o            (config_strap_o),
    .config_strap_valid_o      (config_strap_valid_o),
    .irq_o                     (irq_o)
  );

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
  end

  always #25 clock_i = ~clock_i;

  // a two-cycle request would count twice here
  always @(posedge clock_i) begin
    if (chip_reset_o === 1'b1) begin
      pulses = pulses + 1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock_i);
    addr_i    <= a;
    wr_data_i <= d;
    wr_en_i   <= 1'b1;
    @(posedge clock_i);
    wr_en_i   <= 1'b0;
    #1;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clock_i);
    addr_i  <= a;
    rd_en_i <= 1'b1;
    @(posedge clock_i);
    rd_en_i <= 1'b0;
    #1;
    check(rd_data_o, exp);
  endtask

  task automatic pend(input int n);
    @(posedge clock_i);
    host_access_pending_i <= 1'b1;
    repeat (n) @(posedge clock_i);
    host_access_pending_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    #1;
  endtask

  task automatic do_reset;
    rst_n_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    #1;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #(50 * 4000);
    errors = errors + 1;
    finish_test();
  end

  initial begin
    int n;
    errors                = 0;
    num_checks            = 0;
    pulses                = 0;
    rst_n_i               = 1'b0;
    addr_i                = 16'h0000;
    wr_data_i             = 16'h0000;
    wr_en_i               = 1'b0;
    rd_en_i               = 1'b0;
    host_access_pending_i = 1'b0;
    config_strap_pins_i   = 9'h15a;
    do_reset();
    check(high_port_group_pd_en_o, 6'h3f);
    check(second_port_group_pd_en_o, 5'h1f);
    check(memory_data_lines_pd_en_o, 32'hffffffff);
    check(config_strap_pins_pd_en_o, 9'h1ff);
    check(io_clk_en_o, 1'b0);
    rd(ADDR_PORT_PD, 16'h0000);
    rd(ADDR_MEM_PD_LO, 16'h0000);
    rd(ADDR_MEM_PD_HI, 16'h0000);
    rd(ADDR_STRAP_PD, 16'h0000);
    rd(ADDR_PWR_SAVE, 16'h0001);
    rd(ADDR_BTO_CTRL, 16'h0001);
    // reserved gap is only read, never written
    rd(ADDR_RSVD_GAP, 16'h0000);
    rd(16'h0500, 16'h0000);

    // strap capture, then pins and pull-downs change without effect
    n = 0;
    while (config_strap_valid_o !== 1'b1 && n < 30) begin
      @(posedge clock_i);
      n = n + 1;
    end
    #1;
    check(config_strap_o, 9'h15a);
    check(config_strap_valid_o, 1'b1);
    @(posedge clock_i);
    config_strap_pins_i <= 9'h0a5;
    wr(ADDR_STRAP_PD, 16'hffff);
    check(config_strap_pins_pd_en_o, 9'h000);
    rd(ADDR_STRAP_PD, 16'h01ff);
    repeat (8) @(posedge clock_i);
    #1;
    check(config_strap_o, 9'h15a);
    rd(ADDR_STRAP_VAL, 16'h815a);

    // port groups: pattern shows bit 8+n to high pin n and bit n to second-group pin n, unused bits dropped
    wr(ADDR_PORT_PD, 16'hea95);
    check(high_port_group_pd_en_o, 6'h15);
    check(second_port_group_pd_en_o, 5'h0a);
    rd(ADDR_PORT_PD, 16'h2a15);
    wr(ADDR_PORT_PD, 16'h3f1f);
    check({high_port_group_pd_en_o, second_port_group_pd_en_o}, 11'h000);

    wr(ADDR_MEM_PD_LO, 16'ha5c3);
    wr(ADDR_MEM_PD_HI, 16'h5a3c);
    check(memory_data_lines_pd_en_o, 32'ha5c35a3c);
    rd(ADDR_MEM_PD_LO, 16'ha5c3);
    rd(ADDR_MEM_PD_HI, 16'h5a3c);

    // power save leave and enter; entry raises a masked status
    wr(ADDR_PWR_SAVE, 16'hfffe);
    check(io_clk_en_o, 1'b1);
    rd(ADDR_PWR_SAVE, 16'h0000);
    wr(ADDR_PWR_SAVE, 16'h0001);
    check(io_clk_en_o, 1'b0);
    check(irq_o, 1'b0);
    // only host-bus registers of this bank are touched during power save
    wr(ADDR_IRQ_MASK, 16'h0002);
    check(irq_o, 1'b1);
    rd(ADDR_IRQ_STATUS, 16'h0002);
    check(irq_o, 1'b0);
    rd(ADDR_IRQ_STATUS, 16'h0000);
    wr(ADDR_IRQ_MASK, 16'h0003);
    wr(ADDR_PWR_SAVE, 16'h0000);

    // time-out with the reset function disabled does nothing
    pulses = 0;
    pend(TB_BTO);
    check(pulses, 0);
    rd(ADDR_BTO_CTRL, 16'h0001);
    check(irq_o, 1'b0);
    wr(ADDR_BTO_CTRL, 16'h0000);
    rd(ADDR_BTO_CTRL, 16'h0000);
    pend(TB_BTO - 1);
    check(pulses, 0);
    pend(TB_BTO);
    check(pulses, 1);
    rd(ADDR_BTO_CTRL, 16'h0004);
    check(irq_o, 1'b1);
    rd(ADDR_IRQ_STATUS, 16'h0001);
    check(irq_o, 1'b0);
    rd(ADDR_BTO_CTRL, 16'h0004);
    wr(ADDR_BTO_CTRL, 16'h0002);
    rd(ADDR_BTO_CTRL, 16'h0002);
    pulses = 0;
    pend(TB_BTO);
    check(pulses, 1);
    rd(ADDR_BTO_CTRL, 16'h0002);
    rd(ADDR_IRQ_STATUS, 16'h0000);

    // second reset in mid-run restores the second-group and memory pull-downs
    @(posedge clock_i);
    do_reset();
    check(config_strap_valid_o, 1'b0);
    check(second_port_group_pd_en_o, 5'h1f);
    check(memory_data_lines_pd_en_o, 32'hffffffff);
    check(io_clk_en_o, 1'b0);
    rd(ADDR_MEM_PD_HI, 16'h0000);
    finish_test();
  end

endmodule // tb_pdps_regs
